// File: common/focrm_pkg.sv
// Constants, offsets and carrier types of the control-loop monitor bank
package focrm_pkg;

  localparam int unsigned FOCRM_DATA_W = 32;
  localparam int unsigned FOCRM_ADDR_W = 12;
  localparam int unsigned FOCRM_NUM_MON = 7;

  // Fixed-point scaling seen by software, kept for reference only
  localparam int unsigned FOCRM_FRAC_BITS = 27;
  localparam int unsigned FOCRM_VOLT_SCALE = 60;
  localparam int unsigned FOCRM_CURR_DIV = 8;

  typedef logic [FOCRM_ADDR_W-1:0] focrm_addr_t;
  typedef logic [FOCRM_DATA_W-1:0] focrm_word_t;

  // Slot of each monitor register inside the bank
  localparam int unsigned FOCRM_IDX_APPLIED_Q_VOLTAGE = 0;
  localparam int unsigned FOCRM_IDX_ALIGN_CURRENT_REF = 1;
  localparam int unsigned FOCRM_IDX_OPEN_LOOP_SPEED_REF = 2;
  localparam int unsigned FOCRM_IDX_OPEN_LOOP_TORQUE_CURRENT_REF = 3;
  localparam int unsigned FOCRM_IDX_CLOSED_LOOP_SPEED_REF = 4;
  localparam int unsigned FOCRM_IDX_FLUX_CURRENT_REF_CLOSED = 5;
  localparam int unsigned FOCRM_IDX_TORQUE_CURRENT_REF_CLOSED = 6;

  localparam focrm_addr_t FOCRM_OFS_APPLIED_Q_VOLTAGE = 12'h4E8;
  localparam focrm_addr_t FOCRM_OFS_ALIGN_CURRENT_REF = 12'h524;
  localparam focrm_addr_t FOCRM_OFS_OPEN_LOOP_SPEED_REF = 12'h53C;
  localparam focrm_addr_t FOCRM_OFS_OPEN_LOOP_TORQUE_CURRENT_REF = 12'h54C;
  localparam focrm_addr_t FOCRM_OFS_CLOSED_LOOP_SPEED_REF = 12'h5D2;
  localparam focrm_addr_t FOCRM_OFS_FLUX_CURRENT_REF_CLOSED = 12'h604;
  localparam focrm_addr_t FOCRM_OFS_TORQUE_CURRENT_REF_CLOSED = 12'h606;
  localparam focrm_addr_t FOCRM_OFS_CTRL = 12'h7F0;
  localparam focrm_addr_t FOCRM_OFS_STATUS = 12'h7F4;

  localparam focrm_addr_t FOCRM_MON_OFS [FOCRM_NUM_MON] = '{
    FOCRM_OFS_APPLIED_Q_VOLTAGE,
    FOCRM_OFS_ALIGN_CURRENT_REF,
    FOCRM_OFS_OPEN_LOOP_SPEED_REF,
    FOCRM_OFS_OPEN_LOOP_TORQUE_CURRENT_REF,
    FOCRM_OFS_CLOSED_LOOP_SPEED_REF,
    FOCRM_OFS_FLUX_CURRENT_REF_CLOSED,
    FOCRM_OFS_TORQUE_CURRENT_REF_CLOSED
  };

  localparam focrm_word_t FOCRM_MON_RESET = 32'h0000_0000;
  localparam focrm_word_t FOCRM_RD_IDLE = 32'h0000_0000;
  localparam int unsigned FOCRM_CTRL_HOLD_BIT = 0;
  localparam logic FOCRM_HOLD_RESET = 1'h0;

  typedef struct packed {
    logic wr;
    logic rd;
    focrm_addr_t addr;
    focrm_word_t wdata;
  } focrm_bus_req_s;

  typedef struct packed {
    logic valid;
    focrm_word_t value;
  } focrm_mon_upd_s;

endpackage

// File: rtl/focrm_mon_reg.sv
// One read-only monitor word, loaded only by the control algorithm
`timescale 1ns/10ps
module focrm_mon_reg (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire focrm_pkg::focrm_mon_upd_s i_upd,
  input wire logic i_hold,
  output focrm_pkg::focrm_word_t o_value,
  output logic o_captured
);
  import focrm_pkg::*;

  focrm_word_t value_ff;
  logic nxt_capture;

  // Hold freezes the word so a multi-word read stays coherent
  always_comb begin
    nxt_capture = i_upd.valid && !i_hold;
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      value_ff <= FOCRM_MON_RESET;
    end else if (nxt_capture) begin
      value_ff <= i_upd.value;
    end
  end

  assign o_value = value_ff;
  assign o_captured = nxt_capture;

  a_idle_word_stable: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    !nxt_capture |=> $stable(value_ff))
    else $error("monitor word changed without an update");

  a_load_word: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    nxt_capture |=> value_ff == $past(i_upd.value))
    else $error("monitor word did not take the update");

endmodule

// File: rtl/focrm_regs.sv
// Read-only bank of control-loop monitor registers on a plain register port
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/10ps
// Function
// - The applied q-axis voltage is a 32-bit read-only word scaled by 2^27 and 60/sqrt(3).
// - The rotor alignment current reference is a 32-bit read-only word scaled by 2^27 and base current/8.
// - The open-loop speed reference is a 32-bit read-only word scaled by 2^27 and the maximum speed.
// - The open-loop speed word holds the speed at which the motor hands over to closed loop.
// - The open-loop current reference is a 32-bit read-only word scaled by 2^27 and base current/8.
// - The closed-loop speed reference is a 32-bit read-only word scaled by 2^27 and the maximum speed.
// - The flux-loop d-axis current reference is a 32-bit read-only word scaled by 2^27 and base current/8.
// - The torque-loop q-axis current reference is a 32-bit read-only word scaled by 2^27 and base current/8.
// - Every monitor word reads zero after reset until the control algorithm loads it.
module focrm_regs (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire focrm_pkg::focrm_bus_req_s i_bus,
  input wire focrm_pkg::focrm_mon_upd_s i_applied_q_voltage,
  input wire focrm_pkg::focrm_mon_upd_s i_align_current_ref,
  input wire focrm_pkg::focrm_mon_upd_s i_open_loop_speed_ref,
  input wire focrm_pkg::focrm_mon_upd_s i_open_loop_torque_current_ref,
  input wire focrm_pkg::focrm_mon_upd_s i_closed_loop_speed_ref,
  input wire focrm_pkg::focrm_mon_upd_s i_flux_current_ref_closed,
  input wire focrm_pkg::focrm_mon_upd_s i_torque_current_ref_closed,
  output focrm_pkg::focrm_word_t o_rd_data,
  output logic o_rd_valid,
  output logic o_hold
);
  import focrm_pkg::*;

  logic [1:0] rst_sync_ff;
  logic rst_n;

  focrm_mon_upd_s mon_upd [FOCRM_NUM_MON];
  focrm_word_t mon_value [FOCRM_NUM_MON];
  logic [FOCRM_NUM_MON-1:0] captured;
  logic [FOCRM_NUM_MON-1:0] rd_sel;
  logic [FOCRM_NUM_MON-1:0] wr_sel;
  logic rd_unmapped;

  logic hold_ff;
  logic nxt_hold;
  logic [FOCRM_NUM_MON-1:0] fresh_ff;
  logic [FOCRM_NUM_MON-1:0] nxt_fresh;
  focrm_word_t rd_data_ff;
  focrm_word_t nxt_rd_data;
  logic rd_valid_ff;

  // One-hot decode of a bus address onto the monitor slots
  function automatic logic [FOCRM_NUM_MON-1:0] mon_sel(input focrm_addr_t addr);
    logic [FOCRM_NUM_MON-1:0] sel;
    sel = '0;
    for (int i = 0; i < FOCRM_NUM_MON; i++) begin
      sel[i] = (addr == FOCRM_MON_OFS[i]);
    end
    return sel;
  endfunction

  // Reset release is synchronised; assertion stays asynchronous
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'h1};
    end
  end

  assign rst_n = rst_sync_ff[1];

  always_comb begin
    mon_upd[FOCRM_IDX_APPLIED_Q_VOLTAGE] = i_applied_q_voltage;
    mon_upd[FOCRM_IDX_ALIGN_CURRENT_REF] = i_align_current_ref;
    mon_upd[FOCRM_IDX_OPEN_LOOP_SPEED_REF] = i_open_loop_speed_ref;
    mon_upd[FOCRM_IDX_OPEN_LOOP_TORQUE_CURRENT_REF] = i_open_loop_torque_current_ref;
    mon_upd[FOCRM_IDX_CLOSED_LOOP_SPEED_REF] = i_closed_loop_speed_ref;
    mon_upd[FOCRM_IDX_FLUX_CURRENT_REF_CLOSED] = i_flux_current_ref_closed;
    mon_upd[FOCRM_IDX_TORQUE_CURRENT_REF_CLOSED] = i_torque_current_ref_closed;
  end

  // Write data never reaches these words; only the update ports load them
  genvar g;
  generate
    for (g = 0; g < FOCRM_NUM_MON; g++) begin : g_mon
      focrm_mon_reg u_mon (
        .i_core_clk(i_core_clk),
        .i_rst_n(rst_n),
        .i_upd(mon_upd[g]),
        .i_hold(hold_ff),
        .o_value(mon_value[g]),
        .o_captured(captured[g])
      );
    end
  endgenerate

  assign rd_sel = i_bus.rd ? mon_sel(i_bus.addr) : '0;
  assign wr_sel = i_bus.wr ? mon_sel(i_bus.addr) : '0;

  // Read that hits no location of the bank
  assign rd_unmapped = i_bus.rd && !(|rd_sel)
    && i_bus.addr != FOCRM_OFS_CTRL && i_bus.addr != FOCRM_OFS_STATUS;

  // Control word: the only writable location
  always_comb begin
    nxt_hold = hold_ff;
    if (i_bus.wr && i_bus.addr == FOCRM_OFS_CTRL) begin
      nxt_hold = i_bus.wdata[FOCRM_CTRL_HOLD_BIT];
    end
  end

  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_ff <= FOCRM_HOLD_RESET;
    end else begin
      hold_ff <= nxt_hold;
    end
  end

  // Fresh flags: a load in the same cycle as the read that clears wins
  always_comb begin
    nxt_fresh = (fresh_ff & ~rd_sel) | captured;
  end

  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      fresh_ff <= '0;
    end else begin
      fresh_ff <= nxt_fresh;
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    nxt_rd_data = FOCRM_RD_IDLE;
    if (i_bus.rd) begin
      for (int i = 0; i < FOCRM_NUM_MON; i++) begin
        if (rd_sel[i]) begin
          nxt_rd_data = mon_value[i];
        end
      end
      if (i_bus.addr == FOCRM_OFS_CTRL) begin
        nxt_rd_data = {{(FOCRM_DATA_W-1){1'h0}}, hold_ff};
      end
      if (i_bus.addr == FOCRM_OFS_STATUS) begin
        nxt_rd_data = {{(FOCRM_DATA_W-FOCRM_NUM_MON){1'h0}}, fresh_ff};
      end
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_ff <= FOCRM_RD_IDLE;
      rd_valid_ff <= 1'h0;
    end else begin
      rd_data_ff <= nxt_rd_data;
      rd_valid_ff <= i_bus.rd;
    end
  end

  assign o_rd_data = rd_data_ff;
  assign o_rd_valid = rd_valid_ff;
  assign o_hold = hold_ff;

  default clocking cb_core @(posedge i_core_clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_read(focrm_addr_t ofs);
    i_bus.rd && i_bus.addr == ofs;
  endsequence

  sequence s_load(int unsigned idx);
    mon_upd[idx].valid && !hold_ff;
  endsequence

  sequence s_write(focrm_addr_t ofs);
    i_bus.wr && i_bus.addr == ofs;
  endsequence

  property p_readback(focrm_addr_t ofs, int unsigned idx);
    s_read(ofs) |=> o_rd_valid && o_rd_data == $past(mon_value[idx]);
  endproperty

  property p_load_then_read(focrm_addr_t ofs, int unsigned idx);
    s_load(idx) ##1 s_read(ofs) |=> o_rd_data == $past(mon_upd[idx].value, 2);
  endproperty

  property p_port_lands(focrm_mon_upd_s upd, int unsigned idx);
    upd.valid && !hold_ff |=> mon_value[idx] == $past(upd.value);
  endproperty

  a_vq_readback: assert property (
    p_readback(FOCRM_OFS_APPLIED_Q_VOLTAGE, FOCRM_IDX_APPLIED_Q_VOLTAGE))
    else $error("applied q voltage readback wrong");

  a_align_readback: assert property (
    p_readback(FOCRM_OFS_ALIGN_CURRENT_REF, FOCRM_IDX_ALIGN_CURRENT_REF))
    else $error("align current readback wrong");

  a_ol_speed_readback: assert property (
    p_readback(FOCRM_OFS_OPEN_LOOP_SPEED_REF, FOCRM_IDX_OPEN_LOOP_SPEED_REF))
    else $error("open-loop speed readback wrong");

  a_handover_speed_kept: assert property (
    p_load_then_read(FOCRM_OFS_OPEN_LOOP_SPEED_REF, FOCRM_IDX_OPEN_LOOP_SPEED_REF))
    else $error("handover speed not returned after load");

  a_ol_current_readback: assert property (
    p_readback(FOCRM_OFS_OPEN_LOOP_TORQUE_CURRENT_REF, FOCRM_IDX_OPEN_LOOP_TORQUE_CURRENT_REF))
    else $error("open-loop current readback wrong");

  a_cl_speed_readback: assert property (
    p_readback(FOCRM_OFS_CLOSED_LOOP_SPEED_REF, FOCRM_IDX_CLOSED_LOOP_SPEED_REF))
    else $error("closed-loop speed readback wrong");

  a_flux_ref_readback: assert property (
    p_readback(FOCRM_OFS_FLUX_CURRENT_REF_CLOSED, FOCRM_IDX_FLUX_CURRENT_REF_CLOSED))
    else $error("flux current readback wrong");

  a_torque_ref_readback: assert property (
    p_readback(FOCRM_OFS_TORQUE_CURRENT_REF_CLOSED, FOCRM_IDX_TORQUE_CURRENT_REF_CLOSED))
    else $error("torque current readback wrong");

  a_reset_words_zero: assert property (
    $rose(rst_n) |-> mon_value[FOCRM_IDX_APPLIED_Q_VOLTAGE] == FOCRM_MON_RESET
      && mon_value[FOCRM_IDX_OPEN_LOOP_SPEED_REF] == FOCRM_MON_RESET
      && mon_value[FOCRM_IDX_TORQUE_CURRENT_REF_CLOSED] == FOCRM_MON_RESET
      && fresh_ff == '0)
    else $error("monitor words not zero after reset");

  a_write_no_effect: assert property (
    (|wr_sel) && !(|captured) |=> $stable(mon_value[FOCRM_IDX_FLUX_CURRENT_REF_CLOSED])
      && $stable(mon_value[FOCRM_IDX_CLOSED_LOOP_SPEED_REF]) && $stable(hold_ff))
    else $error("write to monitor word changed state");

  a_read_one_cycle: assert property (
    !i_bus.rd |=> !o_rd_valid && o_rd_data == FOCRM_RD_IDLE)
    else $error("read data outside its cycle");

  a_fresh_set_wins: assert property (
    captured[FOCRM_IDX_ALIGN_CURRENT_REF] |=> fresh_ff[FOCRM_IDX_ALIGN_CURRENT_REF])
    else $error("fresh flag lost on load");

  a_fresh_clear_on_read: assert property (
    rd_sel[FOCRM_IDX_ALIGN_CURRENT_REF] && !captured[FOCRM_IDX_ALIGN_CURRENT_REF]
      |=> !fresh_ff[FOCRM_IDX_ALIGN_CURRENT_REF])
    else $error("fresh flag not cleared by read");

  a_hold_freezes: assert property (
    hold_ff ##1 hold_ff |-> $stable(mon_value[FOCRM_IDX_OPEN_LOOP_SPEED_REF]))
    else $error("word changed while held");

  a_ctrl_write: assert property (
    s_write(FOCRM_OFS_CTRL)
      |=> o_hold == $past(i_bus.wdata[FOCRM_CTRL_HOLD_BIT]))
    else $error("hold bit not written");

  a_wr_elsewhere_hold: assert property (
    i_bus.wr && i_bus.addr != FOCRM_OFS_CTRL |=> $stable(hold_ff))
    else $error("write elsewhere changed hold");

  a_write_keeps_words: assert property (
    (|wr_sel) && !(|captured) |=> $stable(mon_value[FOCRM_IDX_APPLIED_Q_VOLTAGE])
      && $stable(mon_value[FOCRM_IDX_ALIGN_CURRENT_REF]) && $stable(mon_value[FOCRM_IDX_OPEN_LOOP_SPEED_REF])
      && $stable(mon_value[FOCRM_IDX_OPEN_LOOP_TORQUE_CURRENT_REF])
      && $stable(mon_value[FOCRM_IDX_TORQUE_CURRENT_REF_CLOSED]))
    else $error("write to monitor word changed another word");

  // Each update port lands in its own word, so a swapped port shows up
  a_vq_lands: assert property (
    p_port_lands(i_applied_q_voltage, FOCRM_IDX_APPLIED_Q_VOLTAGE))
    else $error("applied q voltage update lost");

  a_align_lands: assert property (
    p_port_lands(i_align_current_ref, FOCRM_IDX_ALIGN_CURRENT_REF))
    else $error("align current update lost");

  a_ol_speed_lands: assert property (
    p_port_lands(i_open_loop_speed_ref, FOCRM_IDX_OPEN_LOOP_SPEED_REF))
    else $error("open-loop speed update lost");

  a_ol_current_lands: assert property (
    p_port_lands(i_open_loop_torque_current_ref, FOCRM_IDX_OPEN_LOOP_TORQUE_CURRENT_REF))
    else $error("open-loop current update lost");

  a_cl_speed_lands: assert property (
    p_port_lands(i_closed_loop_speed_ref, FOCRM_IDX_CLOSED_LOOP_SPEED_REF))
    else $error("closed-loop speed update lost");

  a_flux_lands: assert property (
    p_port_lands(i_flux_current_ref_closed, FOCRM_IDX_FLUX_CURRENT_REF_CLOSED))
    else $error("flux current update lost");

  a_torque_lands: assert property (
    p_port_lands(i_torque_current_ref_closed, FOCRM_IDX_TORQUE_CURRENT_REF_CLOSED))
    else $error("torque current update lost");

  // Software-visible words beside the monitors
  a_ctrl_readback: assert property (
    s_read(FOCRM_OFS_CTRL) |=> o_rd_data == {{(FOCRM_DATA_W-1){1'h0}}, $past(hold_ff)})
    else $error("control word readback wrong");

  a_status_readback: assert property (
    s_read(FOCRM_OFS_STATUS)
      |=> o_rd_data == {{(FOCRM_DATA_W-FOCRM_NUM_MON){1'h0}}, $past(fresh_ff)})
    else $error("status word readback wrong");

  a_status_read_keeps: assert property (
    i_bus.rd && i_bus.addr == FOCRM_OFS_STATUS && !(|captured)
      |=> fresh_ff == $past(fresh_ff))
    else $error("status read changed fresh flags");

  a_unmapped_read_zero: assert property (
    rd_unmapped |=> o_rd_valid && o_rd_data == FOCRM_RD_IDLE)
    else $error("unmapped read not zero");

  a_rd_valid_next: assert property (
    i_bus.rd |=> o_rd_valid)
    else $error("read not answered in next cycle");

  a_fresh_set_speed: assert property (
    captured[FOCRM_IDX_OPEN_LOOP_SPEED_REF] |=> fresh_ff[FOCRM_IDX_OPEN_LOOP_SPEED_REF])
    else $error("speed fresh flag lost on load");

  a_hold_no_fresh: assert property (
    hold_ff |=> (fresh_ff & ~$past(fresh_ff)) == '0)
    else $error("fresh flag set while held");

  a_hold_freezes_all: assert property (
    hold_ff |=> $stable(mon_value[FOCRM_IDX_APPLIED_Q_VOLTAGE])
      && $stable(mon_value[FOCRM_IDX_ALIGN_CURRENT_REF])
      && $stable(mon_value[FOCRM_IDX_OPEN_LOOP_TORQUE_CURRENT_REF])
      && $stable(mon_value[FOCRM_IDX_CLOSED_LOOP_SPEED_REF])
      && $stable(mon_value[FOCRM_IDX_FLUX_CURRENT_REF_CLOSED])
      && $stable(mon_value[FOCRM_IDX_TORQUE_CURRENT_REF_CLOSED]))
    else $error("held word changed");

  // Reset covers the words and state not named in the check above
  a_reset_rest_zero: assert property (
    $rose(rst_n) |-> mon_value[FOCRM_IDX_ALIGN_CURRENT_REF] == FOCRM_MON_RESET
      && mon_value[FOCRM_IDX_OPEN_LOOP_TORQUE_CURRENT_REF] == FOCRM_MON_RESET
      && mon_value[FOCRM_IDX_CLOSED_LOOP_SPEED_REF] == FOCRM_MON_RESET
      && mon_value[FOCRM_IDX_FLUX_CURRENT_REF_CLOSED] == FOCRM_MON_RESET
      && hold_ff == FOCRM_HOLD_RESET && !o_rd_valid)
    else $error("bank state not cleared by reset");

endmodule

// File: verification/focrm_regs_tb.sv
// Self-checking testbench of the control-loop monitor register bank
`timescale 1ns/10ps
module focrm_regs_tb;
  import focrm_pkg::*;

  logic i_core_clk;
  logic i_resetn;
  focrm_bus_req_s bus;
  focrm_mon_upd_s upd [FOCRM_NUM_MON];
  focrm_word_t o_rd_data;
  logic o_rd_valid;
  logic o_hold;
  int err_count;
  int n_tests;
  focrm_word_t rdat;

  focrm_regs dut (
    .i_core_clk(i_core_clk),
    .i_resetn(i_resetn),
    .i_bus(bus),
    .i_applied_q_voltage(upd[0]),
    .i_align_current_ref(upd[1]),
    .i_open_loop_speed_ref(upd[2]),
    .i_open_loop_torque_current_ref(upd[3]),
    .i_closed_loop_speed_ref(upd[4]),
    .i_flux_current_ref_closed(upd[5]),
    .i_torque_current_ref_closed(upd[6]),
    .o_rd_data(o_rd_data),
    .o_rd_valid(o_rd_valid),
    .o_hold(o_hold)
  );

  always #5 i_core_clk = ~i_core_clk;

  // Distinct pattern per slot, top nibble set so a narrow word shows up
  function automatic focrm_word_t pat(input int i, input logic [3:0] k);
    pat = {k, 4'(i), 24'h5A3C96};
  endfunction

  task automatic check(input string name, input focrm_word_t seen, input focrm_word_t exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic rd(input focrm_addr_t a, output focrm_word_t d);
    @(posedge i_core_clk);
    bus.rd <= 1'h1;
    bus.addr <= a;
    @(posedge i_core_clk);
    bus.rd <= 1'h0;
    #1;
    check("rd_valid", {31'h0, o_rd_valid}, 32'h1);
    d = o_rd_data;
  endtask

  task automatic wr(input focrm_addr_t a, input focrm_word_t d);
    @(posedge i_core_clk);
    bus.wr <= 1'h1;
    bus.addr <= a;
    bus.wdata <= d;
    @(posedge i_core_clk);
    bus.wr <= 1'h0;
    #1;
  endtask

  task automatic load(input int i, input focrm_word_t v);
    @(posedge i_core_clk);
    upd[i] <= '{valid: 1'h1, value: v};
    @(posedge i_core_clk);
    upd[i].valid <= 1'h0;
  endtask

  task automatic do_reset(input int n);
    @(posedge i_core_clk);
    i_resetn <= 1'h0;
    repeat (n) @(posedge i_core_clk);
    i_resetn <= 1'h1;
    repeat (3) @(posedge i_core_clk);
  endtask

  task automatic t_reset_values();
    for (int i = 0; i < FOCRM_NUM_MON; i++) begin
      rd(FOCRM_MON_OFS[i], rdat);
      check("reset word", rdat, FOCRM_MON_RESET);
    end
    rd(FOCRM_OFS_STATUS, rdat);
    check("reset status", rdat, 32'h0);
    check("reset hold", {31'h0, o_hold}, 32'h0);
  endtask

  // Loads all slots, then reads each word back at its own offset
  task automatic t_load_read();
    for (int i = 0; i < FOCRM_NUM_MON; i++) load(i, pat(i, 4'hA));
    rd(FOCRM_OFS_STATUS, rdat);
    check("fresh flags", rdat, 32'h0000_007F);
    for (int i = 0; i < FOCRM_NUM_MON; i++) begin
      rd(FOCRM_MON_OFS[i], rdat);
      check("word", rdat, pat(i, 4'hA));
    end
    rd(FOCRM_OFS_STATUS, rdat);
    check("fresh cleared", rdat, 32'h0);
  endtask

  // Software writes must leave every monitor word as loaded
  task automatic t_write_ignored();
    for (int i = 0; i < FOCRM_NUM_MON; i++) wr(FOCRM_MON_OFS[i], ~pat(i, 4'hA));
    for (int i = 0; i < FOCRM_NUM_MON; i++) begin
      rd(FOCRM_MON_OFS[i], rdat);
      check("word after write", rdat, pat(i, 4'hA));
    end
    check("hold after writes", {31'h0, o_hold}, 32'h0);
    rd(12'h100, rdat);
    check("unmapped read", rdat, 32'h0);
  endtask

  // Hold drops loads instead of deferring them
  task automatic t_hold();
    wr(FOCRM_OFS_CTRL, 32'h0000_0001);
    check("hold set", {31'h0, o_hold}, 32'h1);
    rd(FOCRM_OFS_CTRL, rdat);
    check("ctrl read", rdat, 32'h0000_0001);
    load(FOCRM_IDX_OPEN_LOOP_SPEED_REF, pat(2, 4'h5));
    load(FOCRM_IDX_FLUX_CURRENT_REF_CLOSED, pat(5, 4'h5));
    rd(FOCRM_OFS_OPEN_LOOP_SPEED_REF, rdat);
    check("held word", rdat, pat(2, 4'hA));
    rd(FOCRM_OFS_FLUX_CURRENT_REF_CLOSED, rdat);
    check("held flux word", rdat, pat(5, 4'hA));
    wr(FOCRM_OFS_CTRL, 32'h0);
    check("hold clear", {31'h0, o_hold}, 32'h0);
    rd(FOCRM_OFS_OPEN_LOOP_SPEED_REF, rdat);
    check("dropped load", rdat, pat(2, 4'hA));
    load(FOCRM_IDX_OPEN_LOOP_SPEED_REF, pat(2, 4'h5));
    rd(FOCRM_OFS_OPEN_LOOP_SPEED_REF, rdat);
    check("handover speed", rdat, pat(2, 4'h5));
  endtask

  // Load beside a read of the same word, then reads with no gap between strobes
  task automatic t_tight();
    @(posedge i_core_clk);
    upd[1] <= '{valid: 1'h1, value: pat(1, 4'h3)};
    upd[2] <= '{valid: 1'h1, value: pat(2, 4'h3)};
    bus.rd <= 1'h1;
    bus.addr <= FOCRM_OFS_ALIGN_CURRENT_REF;
    @(posedge i_core_clk);
    upd[1].valid <= 1'h0;
    upd[2].valid <= 1'h0;
    bus.addr <= FOCRM_OFS_OPEN_LOOP_SPEED_REF;
    #1;
    check("read beside load", o_rd_data, pat(1, 4'hA));
    @(posedge i_core_clk);
    bus.addr <= FOCRM_OFS_STATUS;
    #1;
    check("load then read", o_rd_data, pat(2, 4'h3));
    @(posedge i_core_clk);
    bus.rd <= 1'h0;
    #1;
    check("set wins", o_rd_data, 32'h0000_0002);
    check("valid on last read", {31'h0, o_rd_valid}, 32'h1);
    rd(FOCRM_OFS_ALIGN_CURRENT_REF, rdat);
    check("loaded beside read", rdat, pat(1, 4'h3));
  endtask

  // Second reset in mid-run clears loaded words again
  task automatic t_mid_reset();
    wr(FOCRM_OFS_CTRL, 32'h0000_0001);
    do_reset(2);
    check("hold after reset", {31'h0, o_hold}, 32'h0);
    for (int i = 0; i < FOCRM_NUM_MON; i++) begin
      rd(FOCRM_MON_OFS[i], rdat);
      check("word after reset", rdat, FOCRM_MON_RESET);
    end
  endtask

  task automatic report_and_stop();
    if (err_count == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    i_core_clk = 1'h0;
    i_resetn = 1'h0;
    bus = '0;
    for (int i = 0; i < FOCRM_NUM_MON; i++) upd[i] = '0;
    err_count = 0;
    n_tests = 0;
    repeat (16) @(posedge i_core_clk);
    i_resetn <= 1'h1;
    repeat (3) @(posedge i_core_clk);
    t_reset_values();
    t_load_read();
    t_write_ignored();
    t_hold();
    t_tight();
    t_mid_reset();
    report_and_stop();
  end

  // Whole run is about 150 cycles; this limit only cuts a hang
  initial begin
    #100000;
    err_count++;
    report_and_stop();
  end
endmodule
